// file: irq_pkg.sv
/*
  constants, register map and field positions of the interrupt enable,
  priority and external request block.
  assumes an apb slave with 32-bit data, one word per register.
*/
package irq_pkg;
  localparam int NSRC = 6;
  localparam logic [11:0] ADDR_GATE = 12'h000;
  localparam logic [11:0] ADDR_LEVEL = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;
  localparam logic [11:0] ADDR_MASK = 12'h010;
  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] GATE_WMASK = 8'hbf;
  localparam logic [7:0] LEVEL_WMASK = 8'h3f;
  localparam int GLOBAL_BIT = 7;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER = 4;
  localparam int SRC_TMR2 = 5;
  localparam int CTL_TF1 = 7;
  localparam int CTL_RUN1 = 6;
  localparam int CTL_TF0 = 5;
  localparam int CTL_RUN0 = 4;
  localparam int CTL_X1F = 3;
  localparam int CTL_X1E = 2;
  localparam int CTL_X0F = 1;
  localparam int CTL_X0E = 0;
  localparam logic [7:0] CTRL_SW_MASK = 8'h55;
  localparam int STAT_VEC = 0;
  localparam int STAT_ERR = 1;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // fixed order within a level: lowest source index wins
  function automatic logic [2:0] first_set(input logic [NSRC-1:0] req);
    first_set = 3'd7;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction : first_set

  function automatic logic [15:0] vec_of(input logic [2:0] src);
    vec_of = VEC_BASE + 16'(src) * VEC_STEP;
  endfunction : vec_of
endpackage : irq_pkg

// file: ext_trigger.sv
/*
  one external request channel: falling edge latch or low level follower.
  assumes the pin is already synchronous to pclk.
*/
`timescale 1ns/1ps
module ext_trigger
  import irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_n,
  input wire logic edge_sel,
  input wire logic ack,
  output logic req_flag
);
  logic pin_d_ff;
  logic fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_ff <= 1'b1;
    end else begin
      pin_d_ff <= pin_n;
    end
  end

  assign fall = pin_d_ff & ~pin_n;

  // set wins over the vectoring clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_flag <= 1'b0;
    end else if (!edge_sel) begin
      req_flag <= ~pin_n;
    end else if (fall) begin
      req_flag <= 1'b1;
    end else if (ack) begin
      req_flag <= 1'b0;
    end
  end

  chk_level_follow: assert property (@(posedge pclk) disable iff (!presetn)
      !edge_sel ##1 !$past(edge_sel) |-> req_flag == !$past(pin_n))
    else $error("level mode request does not follow pin");
  chk_edge_latch: assert property (@(posedge pclk) disable iff (!presetn)
      edge_sel && fall |=> req_flag)
    else $error("falling edge not latched");
endmodule : ext_trigger

// file: prio_select.sv
/*
  two level priority pick with fixed order inside each level.
  assumes request and level vectors are registered upstream.
*/
`timescale 1ns/1ps
module prio_select
  import irq_pkg::*;
(
  input wire logic [NSRC-1:0] req,
  input wire logic [NSRC-1:0] level,
  output logic pick_valid,
  output logic pick_high,
  output logic [2:0] pick_src
);
  logic [NSRC-1:0] hi_req;
  logic [NSRC-1:0] lo_req;

  assign hi_req = req & level;
  assign lo_req = req & ~level;

  always_comb begin
    pick_valid = |req;
    pick_high = |hi_req;
    if (|hi_req) begin
      pick_src = first_set(hi_req);
    end else begin
      pick_src = first_set(lo_req);
    end
  end
endmodule : prio_select

// file: irq_enable_priority_ctrl.sv
/*
  apb register block plus interrupt request, priority and vectoring logic.
  assumes the core pulses vec_take when it accepts vec_addr, and ret_pulse
  on return from a service routine; source inputs are pclk synchronous.
*/
`timescale 1ns/1ps
module irq_enable_priority_ctrl
  import irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext0_pin_n,
  input wire logic ext1_pin_n,
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  input wire logic receive_done,
  input wire logic transmit_done,
  input wire logic tmr2_wrap_flag,
  input wire logic tmr2_ext_flag,
  input wire logic vec_take,
  input wire logic ret_pulse,
  output logic cpu_irq_req,
  output logic [15:0] vec_addr,
  output logic tmr0_run,
  output logic tmr1_run,
  output logic irq_out
);
  typedef enum logic [1:0] {IDLE, OFFERED} vec_state_t;

  logic [7:0] gate_ff;
  logic [7:0] level_ff;
  logic [7:0] ctrl_sw_ff;
  logic tf0_ff;
  logic tf1_ff;
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;
  logic act_hi_ff;
  logic act_lo_ff;
  vec_state_t st_ff;
  logic [2:0] src_ff;
  logic x0_flag;
  logic x1_flag;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] req;
  logic pick_valid;
  logic pick_high;
  logic [2:0] pick_src;
  logic allowed;
  logic wr;
  logic rd;
  logic [7:0] ctrl_view;
  logic take;
  logic [NSRC-1:0] ack;
  logic [31:0] nxt_rdata;
  logic nxt_err;

  // a write lands only at the edge that completes the transfer
  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & penable & ~pwrite;
  assign take = (st_ff == OFFERED) & vec_take;

  // one-hot clear of the source being vectored
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_ack
      assign ack[g] = take && (src_ff == 3'(g));
    end
  endgenerate

  ext_trigger u_ext0 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_n(ext0_pin_n),
    .edge_sel(ctrl_sw_ff[CTL_X0E]),
    .ack(ack[SRC_EXT0]),
    .req_flag(x0_flag)
  );

  ext_trigger u_ext1 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_n(ext1_pin_n),
    .edge_sel(ctrl_sw_ff[CTL_X1E]),
    .ack(ack[SRC_EXT1]),
    .req_flag(x1_flag)
  );

  // serial and timer 2 flags are cleared by software in their own units
  assign pend[SRC_EXT0] = x0_flag;
  assign pend[SRC_TMR0] = tf0_ff;
  assign pend[SRC_EXT1] = x1_flag;
  assign pend[SRC_TMR1] = tf1_ff;
  assign pend[SRC_SER] = receive_done | transmit_done;
  assign pend[SRC_TMR2] = tmr2_wrap_flag | tmr2_ext_flag;

  // bit 6 never reaches a source, so a reserved one stays inert
  assign req = pend & gate_ff[NSRC-1:0] & {NSRC{gate_ff[GLOBAL_BIT]}};

  prio_select u_prio (
    .req(req),
    .level(level_ff[NSRC-1:0]),
    .pick_valid(pick_valid),
    .pick_high(pick_high),
    .pick_src(pick_src)
  );

  // high may preempt low only; nothing preempts high
  assign allowed = pick_valid && !act_hi_ff && (pick_high || !act_lo_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_ff <= GATE_RST;
      level_ff <= LEVEL_RST;
      ctrl_sw_ff <= CTRL_RST;
      mask_ff <= 2'b00;
    end else if (wr) begin
      if (paddr == ADDR_GATE) begin
        gate_ff <= pwdata[7:0] & GATE_WMASK;
      end
      if (paddr == ADDR_LEVEL) begin
        level_ff <= pwdata[7:0] & LEVEL_WMASK;
      end
      if (paddr == ADDR_CTRL) begin
        ctrl_sw_ff <= pwdata[7:0] & CTRL_SW_MASK;
      end
      if (paddr == ADDR_MASK) begin
        mask_ff <= pwdata[1:0];
      end
    end
  end

  // hardware set wins over vectoring clear and software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tf0_ff <= 1'b0;
      tf1_ff <= 1'b0;
    end else begin
      if (tmr0_ovf) begin
        tf0_ff <= 1'b1;
      end else if (ack[SRC_TMR0]) begin
        tf0_ff <= 1'b0;
      end else if (wr && paddr == ADDR_CTRL) begin
        tf0_ff <= pwdata[CTL_TF0];
      end
      if (tmr1_ovf) begin
        tf1_ff <= 1'b1;
      end else if (ack[SRC_TMR1]) begin
        tf1_ff <= 1'b0;
      end else if (wr && paddr == ADDR_CTRL) begin
        tf1_ff <= pwdata[CTL_TF1];
      end
    end
  end

  // offer a vector, update it to the current pick until the core takes it or it is withdrawn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= IDLE;
      src_ff <= 3'd0;
      cpu_irq_req <= 1'b0;
      vec_addr <= 16'h0000;
    end else begin
      case (st_ff)
        IDLE: begin
          if (allowed) begin
            st_ff <= OFFERED;
            src_ff <= pick_src;
            cpu_irq_req <= 1'b1;
            vec_addr <= vec_of(pick_src);
          end
        end
        OFFERED: begin
          if (vec_take || !allowed) begin
            st_ff <= IDLE;
            cpu_irq_req <= 1'b0;
          end else begin
            src_ff <= pick_src;
            vec_addr <= vec_of(pick_src);
          end
        end
        default: begin
          st_ff <= IDLE;
          cpu_irq_req <= 1'b0;
        end
      endcase
    end
  end

  // service-in-progress tracking, one nesting level per priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_hi_ff <= 1'b0;
      act_lo_ff <= 1'b0;
    end else if (take) begin
      if (level_ff[src_ff]) begin
        act_hi_ff <= 1'b1;
      end else begin
        act_lo_ff <= 1'b1;
      end
    end else if (ret_pulse) begin
      if (act_hi_ff) begin
        act_hi_ff <= 1'b0;
      end else begin
        act_lo_ff <= 1'b0;
      end
    end
  end

  // block events: vectoring and a read or write to an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == STAT_VEC && take) || (i == STAT_ERR && nxt_err && psel && penable)) begin
          stat_ff[i] <= 1'b1;
        end else if (wr && paddr == ADDR_STAT && pwdata[i]) begin
          stat_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign ctrl_view = {tf1_ff, ctrl_sw_ff[CTL_RUN1], tf0_ff, ctrl_sw_ff[CTL_RUN0],
                      x1_flag, ctrl_sw_ff[CTL_X1E], x0_flag, ctrl_sw_ff[CTL_X0E]};

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    case (paddr)
      ADDR_GATE: nxt_rdata = {24'h00_0000, gate_ff};
      ADDR_LEVEL: nxt_rdata = {24'h00_0000, level_ff};
      ADDR_CTRL: nxt_rdata = {24'h00_0000, ctrl_view};
      ADDR_STAT: nxt_rdata = {30'h0000_0000, stat_ff};
      ADDR_MASK: nxt_rdata = {30'h0000_0000, mask_ff};
      default: nxt_err = 1'b1;
    endcase
  end

  // one wait state: answer registered during the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & nxt_err;
      if (rd && !pready) begin
        prdata <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr0_run <= 1'b0;
      tmr1_run <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      tmr0_run <= ctrl_sw_ff[CTL_RUN0];
      tmr1_run <= ctrl_sw_ff[CTL_RUN1];
      irq_out <= |(stat_ff & mask_ff);
    end
  end

  chk_gate_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      !gate_ff[GLOBAL_BIT] |=> !cpu_irq_req)
    else $error("request offered with global gate clear");
  chk_enable_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      allowed && st_ff == IDLE |-> gate_ff[pick_src])
    else $error("disabled source picked");
  chk_no_preempt: assert property (@(posedge pclk) disable iff (!presetn)
      act_hi_ff |=> !cpu_irq_req)
    else $error("high service preempted");
  chk_same_level: assert property (@(posedge pclk) disable iff (!presetn)
      act_lo_ff && st_ff == IDLE && !(|(req & level_ff[NSRC-1:0])) |=> !cpu_irq_req)
    else $error("low service preempted by low request");
  chk_tf0_clear: assert property (@(posedge pclk) disable iff (!presetn)
      ack[SRC_TMR0] && !tmr0_ovf |=> !tf0_ff)
    else $error("timer 0 flag not cleared on vectoring");
  chk_tf1_set: assert property (@(posedge pclk) disable iff (!presetn)
      tmr1_ovf |=> tf1_ff)
    else $error("timer 1 flag not set on overflow");
  chk_vec_addr: assert property (@(posedge pclk) disable iff (!presetn)
      cpu_irq_req |-> vec_addr == {10'h000, src_ff, 3'h3})
    else $error("vector address mismatch");
  chk_fixed_order: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff == IDLE && allowed && req[SRC_EXT0] && level_ff[SRC_EXT0] |=> src_ff == 3'd0)
    else $error("ext0 not first in its level");
  chk_run_route: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 tmr0_run == $past(ctrl_sw_ff[CTL_RUN0]))
    else $error("run bit not routed");
  chk_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      !gate_ff[6] && level_ff[7:6] == 2'b00)
    else $error("reserved bit set");
endmodule : irq_enable_priority_ctrl

// file: core_model.sv
/*
  processor core stand-in: takes offered vectors and returns from service.
  assumes the bench gates acceptance and asks for each return.
*/
`timescale 1ns/1ps
module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_irq_req,
  input wire logic [15:0] vec_addr,
  input wire logic accept,
  input wire logic ret_req,
  output logic vec_take,
  output logic ret_pulse,
  output logic [15:0] last_vec,
  output int taken
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_take <= 1'b0;
      ret_pulse <= 1'b0;
      last_vec <= 16'h0000;
      taken <= 0;
    end else begin
      // one pulse per offer, so a standing request is never taken twice
      vec_take <= accept && cpu_irq_req && !vec_take;
      ret_pulse <= ret_req;
      if (vec_take && cpu_irq_req) begin
        last_vec <= vec_addr;
        taken <= taken + 1;
      end
    end
  end
endmodule : core_model

// file: irq_enable_priority_ctrl_tb_top.sv
/*
  self-checking bench of the interrupt enable and priority block.
  assumes apb answers with pready and the core model below takes vectors.
*/
`timescale 1ns/1ps
module irq_enable_priority_ctrl_tb_top
  import irq_pkg::*;
();
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, cpu_irq_req, vec_take, ret_pulse, run0, run1, irq_out;
  logic x0_n = 1, x1_n = 1, t0o = 0, t1o = 0, rxd = 0, txd = 0, t2f = 0, t2x = 0;
  logic accept = 0, ret_req = 0;
  logic [15:0] vec_addr, last_vec;
  logic [31:0] seed = 32'h3ca967d2;
  int taken, error_cnt = 0, checked = 0, cyc = 0, pend = 0, gate_m = 0, lvl_m = 0;
  int act[$];

  always #12.5 pclk = ~pclk;

  irq_enable_priority_ctrl dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext0_pin_n(x0_n), .ext1_pin_n(x1_n), .tmr0_ovf(t0o), .tmr1_ovf(t1o),
    .receive_done(rxd), .transmit_done(txd), .tmr2_wrap_flag(t2f), .tmr2_ext_flag(t2x),
    .vec_take(vec_take), .ret_pulse(ret_pulse), .cpu_irq_req(cpu_irq_req),
    .vec_addr(vec_addr), .tmr0_run(run0), .tmr1_run(run1), .irq_out(irq_out)
  );
  core_model core_u (
    .pclk(pclk), .presetn(presetn), .cpu_irq_req(cpu_irq_req), .vec_addr(vec_addr),
    .accept(accept), .ret_req(ret_req), .vec_take(vec_take), .ret_pulse(ret_pulse),
    .last_vec(last_vec), .taken(taken)
  );

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // registered copies of a written value show one edge after the write
    repeat (2) @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rchk

  task automatic chk_vec(input int s);
    int t;
    t = taken;
    accept <= 1'b1;
    for (int n = 0; n < 20 && taken == t; n++) @(posedge pclk);
    accept <= 1'b0;
    @(posedge pclk);
    checked++;
    if (s < 0 ? taken != t : (taken != t + 1 || last_vec !== 16'(3 + 8 * s))) begin
      error_cnt++;
      $display("mismatch at %0t: vector of source %0d", $time, s);
    end
  endtask : chk_vec

  // reference pick: higher level first, then fixed order, above the active level only
  function automatic int pick();
    int p;
    p = gate_m[7] ? pend & gate_m : 0;
    for (int h = 1; h >= 0; h--)
      for (int i = 0; i < 6; i++)
        if (p[i] && lvl_m[i] == h && h > (act.size() ? act[$] : -1)) return i;
    return -1;
  endfunction : pick

  task automatic step();
    int e;
    e = pick();
    chk_vec(e);
    if (e >= 0) pend[e] = 0;
    if (e >= 0) act.push_back(lvl_m[e]);
    if (e == 4) {rxd, txd} <= 2'b00;
    if (e == 5) {t2f, t2x} <= 2'b00;
  endtask : step

  task automatic ret();
    void'(act.pop_back());
    ret_req <= 1'b1;
    @(posedge pclk);
    ret_req <= 1'b0;
    @(posedge pclk);
  endtask : ret

  task automatic fire(input logic [7:0] m);
    {t2x, txd, t2f, rxd} <= {t2x, txd, t2f, rxd} | m[7:4];
    {t1o, x1_n, t0o, x0_n} <= {m[3], ~m[2], m[1], ~m[0]};
    pend = pend | m[5:0] | {m[7:6], 4'h0};
    @(posedge pclk);
    {t1o, x1_n, t0o, x0_n} <= 4'h5;
    @(posedge pclk);
  endtask : fire

  task automatic wgate(input logic [7:0] d);
    gate_m = d;
    apb(1'b1, ADDR_GATE, d);
  endtask : wgate

  initial begin
    int s;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rchk(12'(4 * i), 8'h00);
    chk(32'(irq_out), 32'h0);
    $display("test reset finished");
    repeat (4) begin
      seed = lfsr(seed);
      apb(1'b1, ADDR_GATE, seed[7:0]);
      apb(1'b1, ADDR_LEVEL, seed[15:8]);
      rchk(ADDR_GATE, seed[7:0] & GATE_WMASK);
      rchk(ADDR_LEVEL, seed[15:8] & LEVEL_WMASK);
    end
    apb(1'b1, ADDR_LEVEL, 8'h00);
    apb(1'b1, ADDR_CTRL, 8'h55);
    chk(32'({run1, run0}), 32'h3);
    rchk(ADDR_CTRL, 8'h55);
    apb(1'b1, ADDR_CTRL, 8'h05);
    chk(32'({run1, run0}), 32'h0);
    $display("test registers finished");
    wgate(8'h3f);
    fire(8'h0f);
    step();
    rchk(ADDR_CTRL, 8'haf);
    wgate(8'hbf);
    repeat (4) begin
      step();
      ret();
    end
    rchk(ADDR_CTRL, 8'h05);
    for (int i = 0; i < 8; i++) begin
      s = i < 6 ? i : i - 2;
      wgate(8'(8'h80 | (1 << ((s + 1) % 6))));
      fire(8'(1 << i));
      step();
      wgate(8'(8'h80 | (1 << s)));
      step();
      ret();
    end
    $display("test enables finished");
    lvl_m = 8'h20;
    apb(1'b1, ADDR_LEVEL, 8'h20);
    wgate(8'hbf);
    fire(8'h3f);
    step();
    ret();
    step();
    fire(8'h02);
    step();
    fire(8'h20);
    step();
    repeat (2) ret();
    repeat (4) begin
      step();
      ret();
    end
    $display("test priority finished");
    apb(1'b1, ADDR_CTRL, 8'h00);
    wgate(8'h81);
    x0_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(cpu_irq_req), 32'h1);
    x0_n <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(cpu_irq_req), 32'h0);
    apb(1'b1, ADDR_CTRL, 8'h05);
    x0_n <= 1'b0;
    pend = 1;
    step();
    ret();
    step();
    x0_n <= 1'b1;
    $display("test trigger finished");
    apb(1'b0, 12'h020, 8'h00);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    rchk(ADDR_STAT, 8'h03);
    chk(32'(irq_out), 32'h0);
    apb(1'b1, ADDR_MASK, 8'h02);
    chk(32'(irq_out), 32'h1);
    apb(1'b1, ADDR_STAT, 8'h02);
    chk(32'(irq_out), 32'h0);
    rchk(ADDR_STAT, 8'h01);
    $display("test status finished");
    end_of_test();
  end
endmodule : irq_enable_priority_ctrl_tb_top
